//--- mrs_regs.svh
// constants for the serial slave frame handler
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH

`define MRS_CRC_INIT     16'hFFFF
`define MRS_CRC_POLY     16'hA001
`define MRS_CRC_RESIDUE  16'h0000
`define MRS_CRC_STEPS    8

`define MRS_FN_READ      8'h03
`define MRS_FN_WRITE     8'h10
`define MRS_EXC_FLAG     8'h80
`define MRS_EXC_FUNC     8'h81
`define MRS_EXC_ADDR     8'h82
`define MRS_EXC_VALUE    8'h83

`define MRS_MEAS_BASE    16'h0048
`define MRS_MEAS_COUNT   14
`define MRS_MEAS_END     17'h00056
`define MRS_CLR_BASE     16'h000C
`define MRS_CLR_END      17'h0000E

`define MRS_IDX_ADDR     9'h000
`define MRS_IDX_FUNC     9'h001
`define MRS_IDX_START_HI 9'h002
`define MRS_IDX_START_LO 9'h003
`define MRS_IDX_QTY_HI   9'h004
`define MRS_IDX_QTY_LO   9'h005
`define MRS_IDX_BCNT     9'h006
`define MRS_IDX_DATA     9'h007
`define MRS_IDX_MAX      9'h1FF
`define MRS_READ_LEN     9'h008
`define MRS_WRITE_OVH    9'h009
`define MRS_MIN_LEN      9'h004

`define MRS_RD_HDR       8'h03
`define MRS_EXC_BODY     8'h03
`define MRS_ECHO_BODY    8'h06
`define MRS_POS_ADDR     8'h00
`define MRS_POS_FUNC     8'h01
`define MRS_POS_2        8'h02
`define MRS_POS_3        8'h03
`define MRS_POS_4        8'h04

`define MRS_CLK_HZ       25000000
`define MRS_BAUD         4800
`define MRS_CHAR_BITS    11
`define MRS_GAP_HALF_CHARS 7

`endif

//--- mrs_pkg.sv
// types for the serial slave frame handler
`default_nettype none
package mrs_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_LOAD,
    ST_SEND
  } mrs_state_t;

  typedef enum logic [1:0] {
    KIND_READ,
    KIND_WRITE,
    KIND_EXC
  } mrs_kind_t;
endpackage
`default_nettype wire

//--- mrs_word_mem.sv
// measurement word store with registered read data
`timescale 1ns/1ps
`default_nettype none
module mrs_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 14,
  parameter int AW    = 4
) (
  input  wire logic             core_clk, // system clock
  input  wire logic             rst,      // sync reset, high
  input  wire logic             wr_en,    // write strobe
  input  wire logic [AW-1:0]    wr_addr,  // write word index
  input  wire logic [WIDTH-1:0] wr_data,  // write word
  input  wire logic [AW-1:0]    rd_addr,  // read word index
  output logic      [WIDTH-1:0] rd_data   // word one cycle later
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en && wr_addr < AW'(DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // out-of-range index reads zero rather than an undefined word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_addr < AW'(DEPTH)) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= '0;
    end
  end
endmodule
`default_nettype wire

//--- mrs_frame_handler.sv
// serial slave frame handler: crc, read/write commands, exceptions
// Behaviour
// - frames carry a 16-bit crc; receiver recomputes it, mismatch is error
// - crc accumulator starts at all ones before the first byte
// - each byte is xored into the accumulator low byte only
// - shift right with zero in; xor 0xA001 when a one fell out
// - exactly eight shift steps per byte; final accumulator is the crc
// - crc low byte goes out first, then high byte
// - frame is address, function, data, crc in that order
// - frames for other addresses are ignored, never answered
// - read 0x03 answers address, 0x03, byte count, data, crc
// - write 0x10 answers address, 0x10, start, count, crc
// - registers are 16-bit words, high byte first both ways
// - rejected request answers address, function with top bit, code, crc
// - unsupported function code answers exception code 81
// - register location out of range answers exception code 82
// - out-of-range written value answers code 83 and is not applied
// - one read of fourteen registers from 0x0048 is answered whole
// - writing zeros to two registers at 0x000C clears energy, echoed
`include "mrs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mrs_frame_handler #(
  parameter int GAP_CYCLES = (`MRS_GAP_HALF_CHARS * `MRS_CHAR_BITS
                              * `MRS_CLK_HZ + 2 * `MRS_BAUD - 1)
                             / (2 * `MRS_BAUD),
  parameter int MEAS_AW    = 4
) (
  input  wire logic               core_clk,     // 25 MHz clock
  input  wire logic               rst,          // sync reset, high
  input  wire logic [7:0]         rx_data,      // received byte
  input  wire logic               rx_valid,     // byte strobe
  input  wire logic [7:0]         slave_addr,   // own address
  input  wire logic               tx_ready,     // transmitter takes byte
  input  wire logic               meas_we,      // measurement word write
  input  wire logic [MEAS_AW-1:0] meas_addr,    // index from 0x0048
  input  wire logic [15:0]        meas_data,    // measurement word
  output logic      [7:0]         tx_data,      // byte to send
  output logic                    tx_valid,     // byte offered
  output logic                    busy,         // reply in progress
  output logic                    energy_clear, // clear pulse
  output logic                    frame_drop    // bad frame pulse
);
  localparam int GW = $clog2(GAP_CYCLES + 1);

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = {c[15:8], c[7:0] ^ b};
    for (int i = 0; i < `MRS_CRC_STEPS; i++) begin
      if (r[0]) begin
        r = {1'b0, r[15:1]} ^ `MRS_CRC_POLY;
      end else begin
        r = {1'b0, r[15:1]};
      end
    end
    return r;
  endfunction

  // receive side
  logic [8:0]    rx_cnt;
  logic [15:0]   rx_crc;
  logic [7:0]    rx_addr;
  logic [7:0]    rx_func;
  logic [15:0]   rx_start;
  logic [15:0]   rx_qty;
  logic [7:0]    rx_bcnt;
  logic          rx_nz;
  logic [GW-1:0] gap_cnt;

  wire [15:0] crc_seed    = (rx_cnt == `MRS_IDX_ADDR) ? `MRS_CRC_INIT
                                                      : rx_crc;
  wire [15:0] next_rx_crc = crc_byte(crc_seed, rx_data);
  wire        gap_full    = gap_cnt == GW'(GAP_CYCLES - 1);
  wire        gap_done    = gap_full && !rx_valid;
  wire        frame_end   = gap_done && rx_cnt != `MRS_IDX_ADDR;
  wire [8:0]  data_stop   = `MRS_IDX_DATA + {1'b0, rx_bcnt};
  wire        in_data     = rx_cnt >= `MRS_IDX_DATA && rx_cnt < data_stop;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gap_cnt <= '0;
    end else if (rx_valid) begin
      gap_cnt <= '0;
    end else if (!gap_full) begin
      gap_cnt <= gap_cnt + GW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_cnt <= '0;
      rx_crc <= `MRS_CRC_INIT;
    end else if (rx_valid) begin
      rx_crc <= next_rx_crc;
      if (rx_cnt != `MRS_IDX_MAX) begin
        rx_cnt <= rx_cnt + 9'h001;
      end
    end else if (gap_done) begin
      rx_cnt <= '0;
    end
  end

  // header fields land by position in the frame
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_addr  <= '0;
      rx_func  <= '0;
      rx_start <= '0;
      rx_qty   <= '0;
      rx_bcnt  <= '0;
      rx_nz    <= 1'b0;
    end else if (rx_valid) begin
      unique case (rx_cnt)
        `MRS_IDX_ADDR:     rx_addr <= rx_data;
        `MRS_IDX_FUNC:     rx_func <= rx_data;
        `MRS_IDX_START_HI: rx_start[15:8] <= rx_data;
        `MRS_IDX_START_LO: rx_start[7:0] <= rx_data;
        `MRS_IDX_QTY_HI:   rx_qty[15:8] <= rx_data;
        `MRS_IDX_QTY_LO:   rx_qty[7:0] <= rx_data;
        `MRS_IDX_BCNT:     rx_bcnt <= rx_data;
        default:           ;
      endcase
      if (rx_cnt == `MRS_IDX_ADDR) begin
        rx_nz <= 1'b0;
      end else if (in_data && rx_data != 8'h00) begin
        rx_nz <= 1'b1;
      end
    end
  end

  // frame evaluation at the end of the idle gap
  wire        crc_ok   = rx_crc == `MRS_CRC_RESIDUE;
  wire        for_me   = rx_addr == slave_addr;
  wire        is_read  = rx_func == `MRS_FN_READ;
  wire        is_write = rx_func == `MRS_FN_WRITE;
  wire        len_ok   = is_read  ? rx_cnt == `MRS_READ_LEN :
                         is_write ? rx_cnt == `MRS_WRITE_OVH
                                             + {1'b0, rx_bcnt} :
                         rx_cnt >= `MRS_MIN_LEN;
  wire        good     = crc_ok && len_ok;
  wire        accept   = frame_end && good && for_me && !busy;
  wire [16:0] rx_end   = {1'b0, rx_start} + {1'b0, rx_qty};
  wire        rd_ok    = rx_qty != 16'h0000
                         && rx_start >= `MRS_MEAS_BASE
                         && rx_end <= `MRS_MEAS_END;
  wire        wr_ok    = rx_qty != 16'h0000
                         && rx_start >= `MRS_CLR_BASE
                         && rx_end <= `MRS_CLR_END;
  wire        bcnt_ok  = rx_bcnt == {rx_qty[6:0], 1'b0};
  wire        addr_bad = is_read ? !rd_ok : !wr_ok;
  wire        is_exc   = !(is_read ? rd_ok :
                           is_write ? wr_ok && bcnt_ok && !rx_nz :
                           1'b0);
  wire [7:0]  exc_code = !(is_read || is_write) ? `MRS_EXC_FUNC :
                         addr_bad ? `MRS_EXC_ADDR :
                         `MRS_EXC_VALUE;
  wire        do_clear = accept && is_write && !is_exc;
  wire [7:0]  rd_body  = `MRS_RD_HDR + {rx_qty[6:0], 1'b0};
  wire [7:0]  body_len = is_exc ? `MRS_EXC_BODY :
                         is_read ? rd_body : `MRS_ECHO_BODY;
  wire mrs_pkg::mrs_kind_t kind_in = is_exc ? mrs_pkg::KIND_EXC :
                                     is_read ? mrs_pkg::KIND_READ :
                                     mrs_pkg::KIND_WRITE;

  // transmit side
  mrs_pkg::mrs_state_t state;
  mrs_pkg::mrs_kind_t  tx_kind;
  logic [7:0]          tx_addr;
  logic [7:0]          tx_func;
  logic [7:0]          tx_code;
  logic [15:0]         tx_start;
  logic [15:0]         tx_qty;
  logic [7:0]          tx_pos;
  logic [7:0]          tx_len;
  logic [15:0]         tx_crc;
  logic [15:0]         mem_q;

  wire [7:0]  word_off = tx_pos - `MRS_RD_HDR;
  wire [15:0] rd_idx   = tx_start - `MRS_MEAS_BASE
                         + {9'h000, word_off[7:1]};
  wire [7:0]  data_b   = word_off[0] ? mem_q[7:0] : mem_q[15:8];
  wire [7:0]  func_out = (tx_kind == mrs_pkg::KIND_EXC)
                         ? (tx_func | `MRS_EXC_FLAG) : tx_func;
  wire [7:0]  echo_b   = tx_pos == `MRS_POS_2 ? tx_start[15:8] :
                         tx_pos == `MRS_POS_3 ? tx_start[7:0] :
                         tx_pos == `MRS_POS_4 ? tx_qty[15:8] :
                         tx_qty[7:0];
  wire [7:0]  read_b   = tx_pos == `MRS_POS_2 ? {tx_qty[6:0], 1'b0}
                                              : data_b;
  wire [7:0]  kind_b   = tx_kind == mrs_pkg::KIND_READ  ? read_b :
                         tx_kind == mrs_pkg::KIND_WRITE ? echo_b :
                         tx_code;
  wire [7:0]  body_b   = tx_pos == `MRS_POS_ADDR ? tx_addr :
                         tx_pos == `MRS_POS_FUNC ? func_out : kind_b;
  wire        in_body  = tx_pos < tx_len;
  wire [7:0]  crc_b    = tx_pos == tx_len ? tx_crc[7:0]
                                          : tx_crc[15:8];
  wire [7:0]  cur_byte = in_body ? body_b : crc_b;
  wire        last     = tx_pos == tx_len + 8'h01;
  wire        handshake = state == mrs_pkg::ST_SEND && tx_ready;

  mrs_word_mem #(
    .WIDTH (16),
    .DEPTH (`MRS_MEAS_COUNT),
    .AW    (MEAS_AW)
  ) u_mem (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (meas_we),
    .wr_addr  (meas_addr),
    .wr_data  (meas_data),
    .rd_addr  (rd_idx[MEAS_AW-1:0]),
    .rd_data  (mem_q)
  );

  // request fields are copied so a new frame cannot disturb the reply
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_kind  <= mrs_pkg::KIND_EXC;
      tx_addr  <= '0;
      tx_func  <= '0;
      tx_code  <= '0;
      tx_start <= '0;
      tx_qty   <= '0;
      tx_len   <= '0;
    end else if (accept) begin
      tx_kind  <= kind_in;
      tx_addr  <= rx_addr;
      tx_func  <= rx_func;
      tx_code  <= exc_code;
      tx_start <= rx_start;
      tx_qty   <= rx_qty;
      tx_len   <= body_len;
    end
  end

  // fetch cycle gives the word store one edge to present its data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state    <= mrs_pkg::ST_IDLE;
      busy     <= 1'b0;
      tx_pos   <= '0;
      tx_crc   <= `MRS_CRC_INIT;
      tx_data  <= '0;
      tx_valid <= 1'b0;
    end else begin
      unique case (state)
        mrs_pkg::ST_IDLE: begin
          if (accept) begin
            state  <= mrs_pkg::ST_FETCH;
            busy   <= 1'b1;
            tx_pos <= '0;
            tx_crc <= `MRS_CRC_INIT;
          end
        end
        mrs_pkg::ST_FETCH: state <= mrs_pkg::ST_LOAD;
        mrs_pkg::ST_LOAD: begin
          tx_data  <= cur_byte;
          tx_valid <= 1'b1;
          state    <= mrs_pkg::ST_SEND;
        end
        mrs_pkg::ST_SEND: begin
          if (handshake) begin
            tx_valid <= 1'b0;
            if (in_body) begin
              tx_crc <= crc_byte(tx_crc, tx_data);
            end
            if (last) begin
              state <= mrs_pkg::ST_IDLE;
              busy  <= 1'b0;
            end else begin
              tx_pos <= tx_pos + 8'h01;
              state  <= mrs_pkg::ST_FETCH;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      energy_clear <= 1'b0;
      frame_drop   <= 1'b0;
    end else begin
      energy_clear <= do_clear;
      frame_drop   <= frame_end && !good;
    end
  end
endmodule
`default_nettype wire

//--- mrs_frame_chk.sv
// port assertions for the serial slave frame handler
`timescale 1ns/1ps
`default_nettype none
module mrs_frame_chk #(
  parameter int GAP_CYCLES = 40,
  parameter int MEAS_AW    = 4
) (
  input wire logic               core_clk,     // clock
  input wire logic               rst,          // sync reset
  input wire logic [7:0]         rx_data,      // request byte
  input wire logic               rx_valid,     // request strobe
  input wire logic [7:0]         slave_addr,   // own address
  input wire logic               tx_ready,     // reply taken
  input wire logic               meas_we,      // word write
  input wire logic [MEAS_AW-1:0] meas_addr,    // word index
  input wire logic [15:0]        meas_data,    // word value
  input wire logic [7:0]         tx_data,      // reply byte
  input wire logic               tx_valid,     // reply offered
  input wire logic               busy,         // reply running
  input wire logic               energy_clear, // clear pulse
  input wire logic               frame_drop    // drop pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_gap;
    !tx_valid ##1 !tx_valid ##1 tx_valid;
  endsequence
  sequence s_lead;
    !tx_valid ##1 !tx_valid ##1 (tx_valid && tx_data == slave_addr);
  endsequence
  hold_data_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("reply byte not held");
  valid_busy_a: assert property (tx_valid |-> busy)
    else $error("byte offered while idle");
  first_addr_a: assert property ($rose(busy) |-> s_lead)
    else $error("reply does not open with own address");
  byte_gap_a: assert property (tx_valid && tx_ready |=>
    if (busy) s_gap else !tx_valid) else $error("byte spacing wrong");
  clear_pulse_a: assert property (energy_clear |=> !energy_clear)
    else $error("clear pulse too long");
  drop_pulse_a: assert property (frame_drop |=> !frame_drop)
    else $error("drop pulse too long");
  clear_echo_a: assert property (energy_clear |-> busy ##2 tx_valid)
    else $error("clear not echoed");
  drop_silent_a: assert property (frame_drop |->
    !energy_clear && !$rose(busy)) else $error("dropped frame answered");
endmodule
bind mrs_frame_handler mrs_frame_chk #(
  .GAP_CYCLES(GAP_CYCLES),
  .MEAS_AW(MEAS_AW)
) u_mrs_frame_chk (
  .core_clk(core_clk), .rst(rst), .rx_data(rx_data),
  .rx_valid(rx_valid), .slave_addr(slave_addr), .tx_ready(tx_ready),
  .meas_we(meas_we), .meas_addr(meas_addr), .meas_data(meas_data),
  .tx_data(tx_data), .tx_valid(tx_valid), .busy(busy),
  .energy_clear(energy_clear), .frame_drop(frame_drop)
);
`default_nettype wire

//--- mrs_host_model.sv
// host model: sends requests with crc, collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module mrs_host_model (
  input  wire logic       core_clk, // clock
  input  wire logic [7:0] tx_data,  // reply byte
  input  wire logic       tx_valid, // reply offered
  input  wire logic       slow,     // stall reply bytes
  output logic            tx_ready, // reply taken
  output logic      [7:0] rx_data,  // request byte
  output logic            rx_valid  // request strobe
);
  logic [7:0] got[$];
  int         cyc = 0;
  initial begin
    tx_ready = 1'b0;
    rx_data  = 8'h00;
    rx_valid = 1'b0;
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c[7:0] = c[7:0] ^ q[i];
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // bad flag corrupts the crc on purpose; host sends any request it is given, in range or not
  task automatic send(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    c = crc16(q);
    if (bad)
      c = ~c;
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(negedge core_clk);
      rx_data  = q[i];
      rx_valid = 1'b1;
      @(negedge core_clk);
      rx_valid = 1'b0;
      rx_data  = ~q[i]; // idle line shows no stale byte
    end
  endtask
  always @(negedge core_clk) begin
    cyc      <= cyc + 1;
    tx_ready <= !slow || (cyc % 3 == 0);
  end
  always @(posedge core_clk)
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
endmodule
`default_nettype wire

//--- tb_top.sv
// testbench for the serial slave frame handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
  n_errors++; $display("Error %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
  localparam int GAP = 40;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        slow     = 1'b0;
  logic        meas_we  = 1'b0;
  logic [3:0]  meas_addr = 4'h0;
  logic [15:0] meas_data = 16'h0000;
  logic [7:0]  rx_data, tx_data;
  logic        rx_valid, tx_ready, tx_valid, busy, energy_clear, frame_drop;
  logic [7:0]  none[$];
  int          n_errors = 0;
  int          n_tests  = 0;
  int          n_clr = 0;
  int          n_drop = 0;
  int          cyc = 0;
  always #20 core_clk = ~core_clk;
  mrs_frame_handler #(.GAP_CYCLES(GAP), .MEAS_AW(4)) u_mrs_frame_handler (
    .core_clk(core_clk), .rst(rst), .rx_data(rx_data),
    .rx_valid(rx_valid), .slave_addr(8'h01), .tx_ready(tx_ready),
    .meas_we(meas_we), .meas_addr(meas_addr), .meas_data(meas_data),
    .tx_data(tx_data), .tx_valid(tx_valid), .busy(busy),
    .energy_clear(energy_clear), .frame_drop(frame_drop));
  mrs_host_model u_mrs_host_model (
    .core_clk(core_clk), .tx_data(tx_data), .tx_valid(tx_valid),
    .slow(slow), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid));
  task conclude;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    n_clr  += (energy_clear === 1'b1);
    n_drop += (frame_drop === 1'b1);
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic run(input logic [7:0] q[$], input bit bad, input bit s,
                     input logic [7:0] e[$]);
    logic [15:0] c;
    int          t;
    slow = s;
    u_mrs_host_model.got.delete();
    u_mrs_host_model.send(q, bad);
    repeat (GAP + 4) @(negedge core_clk);
    for (t = 0; t < 3000 && busy !== 1'b0; t++)
      @(negedge core_clk);
    if (t == 3000) begin
      n_errors++;
      conclude();
    end
    repeat (4) @(negedge core_clk);
    c = u_mrs_host_model.crc16(e);
    if (e.size() > 0)
      e = {e, c[7:0], c[15:8]};
    `CHK("length", e.size(), u_mrs_host_model.got.size())
    foreach (e[i]) `CHK("byte", e[i], u_mrs_host_model.got[i])
  endtask
  task automatic t_read(input int n, input bit s);
    logic [7:0] e[$];
    e = '{8'h01, 8'h03, 8'(2 * n)};
    for (int i = 0; i < n; i++)
      e = {e, 8'hA5, 8'(i)};
    run('{8'h01, 8'h03, 8'h00, 8'h48, 8'h00, 8'(n)}, 0, s, e);
  endtask
  task automatic t_clear;
    int          n;
    logic [15:0] ec;
    n = n_clr;
    run('{8'h01, 8'h10, 8'h00, 8'h0C, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00,
      8'h00, 8'h00}, 0, 1, '{8'h01, 8'h10, 8'h00, 8'h0C, 8'h00, 8'h02});
    `CHK("clears", n + 1, n_clr)
    ec = {u_mrs_host_model.got[7], u_mrs_host_model.got[6]};
    `CHK("echo crc", 16'hCB81, ec)
  endtask
  task automatic t_bad_func;
    run('{8'h01, 8'h04, 8'h00, 8'h48, 8'h00, 8'h01}, 0, 0,
      '{8'h01, 8'h84, 8'h81});
  endtask
  task automatic t_bad_addr;
    run('{8'h01, 8'h03, 8'h00, 8'h47, 8'h00, 8'h01}, 0, 0,
      '{8'h01, 8'h83, 8'h82});
    run('{8'h01, 8'h03, 8'h00, 8'h48, 8'h00, 8'h0F}, 0, 0,
      '{8'h01, 8'h83, 8'h82});
    run('{8'h01, 8'h10, 8'h00, 8'h0D, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00,
      8'h00, 8'h00}, 0, 0, '{8'h01, 8'h90, 8'h82});
  endtask
  task automatic t_bad_value;
    int n;
    n = n_clr;
    run('{8'h01, 8'h10, 8'h00, 8'h0C, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00,
      8'h00, 8'h01}, 0, 1, '{8'h01, 8'h90, 8'h83});
    run('{8'h01, 8'h10, 8'h00, 8'h0C, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00},
      0, 0, '{8'h01, 8'h90, 8'h83});
    `CHK("no clear", n, n_clr)
  endtask
  task automatic t_drop;
    int n;
    n = n_drop;
    run('{8'h01, 8'h03, 8'h00, 8'h48, 8'h00, 8'h01}, 1, 0, none);
    `CHK("drops", n + 1, n_drop)
    run('{8'h02, 8'h03, 8'h00, 8'h48, 8'h00, 8'h01}, 0, 0, none);
    `CHK("drops", n + 1, n_drop)
    run('{8'h01, 8'h03, 8'h00, 8'h48, 8'h00}, 0, 0, none);
    `CHK("drops", n + 2, n_drop)
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 14; i++) begin
      meas_we   = 1'b1;
      meas_addr = 4'(i);
      meas_data = {8'hA5, 8'(i)};
      @(negedge core_clk);
    end
    meas_we = 1'b0;
    t_read(2, 1'b1);
    t_read(14, 1'b0);
    t_clear();
    t_bad_func();
    t_bad_addr();
    t_bad_value();
    t_drop();
    conclude();
  end
endmodule
`default_nettype wire
